// file: dcd_regs.svh
`ifndef DCD_REGS_SVH
`define DCD_REGS_SVH

// ----------------------------------------------------------------------------
// address field positions
// ----------------------------------------------------------------------------
`define DCD_AP_BIT 10
`define DCD_BC_BIT 12
`define DCD_COL_HI_BIT 11
`define DCD_COL_TOP_BIT 13

// ----------------------------------------------------------------------------
// burst occupancy in clocks, minus one
// ----------------------------------------------------------------------------
`define DCD_BL8_CYCLES 3'h3
`define DCD_BC4_CYCLES 3'h1

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define DCD_PIN_RESET 1'h1
`define DCD_CKE_RESET 1'h0

`endif

// file: dcd_pkg.sv
package dcd_pkg;

  // --------------------------------------------------------------------------
  // command codes
  // --------------------------------------------------------------------------
  typedef enum logic [3:0] {
    DCD_CMD_NOP = 4'h0,
    DCD_CMD_DESELECT = 4'h1,
    DCD_CMD_MODE_SET = 4'h2,
    DCD_CMD_REFRESH = 4'h3,
    DCD_CMD_SREF_ENTER = 4'h4,
    DCD_CMD_SREF_EXIT = 4'h5,
    DCD_CMD_PRECHARGE = 4'h6,
    DCD_CMD_PRECHARGE_ALL = 4'h7,
    DCD_CMD_ACTIVATE = 4'h8,
    DCD_CMD_WRITE = 4'h9,
    DCD_CMD_READ = 4'hA,
    DCD_CMD_PDOWN_ENTER = 4'hB,
    DCD_CMD_PDOWN_EXIT = 4'hC,
    DCD_CMD_ZQ_LONG = 4'hD,
    DCD_CMD_ZQ_SHORT = 4'hE
  } dcd_cmd_e;

  // --------------------------------------------------------------------------
  // power state, gray along active -> power-down -> self refresh
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    DCD_ST_ACTIVE = 2'h0,
    DCD_ST_PDOWN = 2'h1,
    DCD_ST_SREF = 2'h3
  } dcd_state_e;

  // decoded command, fixed maximum widths; unused high bits are zero
  typedef struct packed {
    logic valid;
    dcd_cmd_e code;
    logic [2:0] bank;
    logic [15:0] row;
    logic [11:0] col;
    logic [15:0] opcode;
    logic auto_pre;
    logic bc4;
  } dcd_cmd_s;

  // command pins as sampled
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
    logic odt;
    logic [2:0] ba;
    logic [15:0] addr;
  } dcd_pins_s;

endpackage : dcd_pkg

// file: dcd_decoder.sv
`include "dcd_regs.svh"

// Notes on behaviour
// R1: Each command is decoded from chip select, row strobe, column strobe, write enable and clock enable at the rising edge.
// R2: Bank, row and column widths are parameters because their top bits depend on density and organisation.
// R3: Bank-targeted commands carry the bank address inputs as the target bank.
// R4: Mode set is all four strobes low with clock enable high twice, bank picks the register, address is the opcode.
// R5: Write is select low, row strobe high, column strobe low, write enable low, with bank and column.
// R6: Read is select low, row strobe high, column strobe low, write enable high, with bank and column.
// R7: The auto-precharge address bit high on read or write asks for auto precharge, low leaves the bank open.
// R8: With on-the-fly burst length enabled, burst-chop bit low gives a 4-beat chop and high an 8-beat burst.
// R9: A started burst runs to its end, and fixed versus on-the-fly length comes from mode configuration.
// R10: A no-operation never ends an operation in progress such as a running burst.
// R11: Chip select high is deselect and acts as a no-operation whatever the other inputs are.
// R12: Self refresh exit is sensed asynchronously from the clock enable pin without relying on the clock.
// R13: No refresh activity takes place during power-down.
// R14: Decoding ignores the termination input and termination is off throughout self refresh.
// R15: The controller keeps the asynchronous reset high during every normal command.
// R16: Precharge is select, row strobe, write enable low, column strobe high; activate carries the row.
// R17: Self refresh entry is refresh with clock enable falling, power-down uses nop or deselect, ZQ uses the AP bit.
module dcd_decoder #(
  parameter int BA_W = 3,
  parameter int ROW_W = 15,
  parameter int COL_W = 10
) (
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST_B,
  // command and address pins
  input wire dcd_pkg::dcd_pins_s I_PINS,
  // mode configuration
  input wire logic I_OTF_EN,
  input wire logic I_FIXED_BC4,
  // decoded command and status
  output dcd_pkg::dcd_cmd_s O_CMD,
  output dcd_pkg::dcd_state_e O_STATE,
  output logic O_CMD_ILLEGAL,
  output logic O_BURST_BUSY,
  output logic O_SREF_WAKE,
  output logic O_SELF_REFRESHING,
  output logic O_ODT_EN
);
  import dcd_pkg::*;

  // --------------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------------
  // the output fields are fixed at their widest, so larger widths cannot be carried
  if (BA_W < 1 || BA_W > 3) begin : g_ba_w_chk
    $error("BA_W must be 1 to 3");
  end
  if (ROW_W < 12 || ROW_W > 16) begin : g_row_w_chk
    $error("ROW_W must be 12 to 16");
  end
  if (COL_W < 10 || COL_W > 12) begin : g_col_w_chk
    $error("COL_W must be 10 to 12");
  end

  // --------------------------------------------------------------------------
  // pin synchroniser
  // --------------------------------------------------------------------------
  // all pins cross together so a command is never split across two samples
  dcd_pins_s pins_meta_reg;
  dcd_pins_s pins_reg;
  logic cke_prev_reg;

  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pins_meta_reg <= '0;
      pins_meta_reg.cs_n <= `DCD_PIN_RESET;
      pins_meta_reg.ras_n <= `DCD_PIN_RESET;
      pins_meta_reg.cas_n <= `DCD_PIN_RESET;
      pins_meta_reg.we_n <= `DCD_PIN_RESET;
      pins_meta_reg.cke <= `DCD_CKE_RESET;
      pins_reg <= '0;
      pins_reg.cs_n <= `DCD_PIN_RESET;
      pins_reg.ras_n <= `DCD_PIN_RESET;
      pins_reg.cas_n <= `DCD_PIN_RESET;
      pins_reg.we_n <= `DCD_PIN_RESET;
      pins_reg.cke <= `DCD_CKE_RESET;
    end else begin
      pins_meta_reg <= I_PINS;
      pins_reg <= pins_meta_reg;
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cke_prev_reg <= `DCD_CKE_RESET;
    end else begin
      cke_prev_reg <= pins_reg.cke;
    end
  end

  // --------------------------------------------------------------------------
  // address fields
  // --------------------------------------------------------------------------
  logic [2:0] bank;
  logic [15:0] row;
  logic [11:0] col_full;
  logic [11:0] col;
  logic ap_bit;
  logic bc4_sel;

  always_comb begin
    bank = '0;
    row = '0;
    bank[BA_W-1:0] = pins_reg.ba[BA_W-1:0]; // R3
    row[ROW_W-1:0] = pins_reg.addr[ROW_W-1:0]; // R2
    col_full = {pins_reg.addr[`DCD_COL_TOP_BIT], pins_reg.addr[`DCD_COL_HI_BIT],
                pins_reg.addr[9:0]};
    col = '0;
    col[COL_W-1:0] = col_full[COL_W-1:0]; // R2
    ap_bit = pins_reg.addr[`DCD_AP_BIT];
    // on-the-fly chop bit only counts when enabled, else the fixed setting
    bc4_sel = I_OTF_EN ? !pins_reg.addr[`DCD_BC_BIT] : I_FIXED_BC4; // R8 R9
  end

  // --------------------------------------------------------------------------
  // command decode
  // --------------------------------------------------------------------------
  // termination input takes no part in decoding
  dcd_state_e state_reg;
  logic [2:0] burst_cnt_reg;
  logic is_nop_des;
  logic is_ref;
  logic cmd_valid;
  logic cmd_bad;
  dcd_cmd_e cmd_code;

  always_comb begin
    is_nop_des = pins_reg.cs_n ||
                 ({pins_reg.ras_n, pins_reg.cas_n, pins_reg.we_n} == 3'h7); // R11
    is_ref = !pins_reg.cs_n &&
             ({pins_reg.ras_n, pins_reg.cas_n, pins_reg.we_n} == 3'h1);
    cmd_valid = 1'b0;
    cmd_bad = 1'b0;
    cmd_code = DCD_CMD_NOP;
    if (!cke_prev_reg) begin
      // clock enable was low: only a rise with nop or deselect leaves the state
      if (pins_reg.cke && state_reg != DCD_ST_ACTIVE) begin
        cmd_valid = 1'b1;
        if (!is_nop_des) begin
          cmd_bad = 1'b1;
        end else if (state_reg == DCD_ST_SREF) begin
          cmd_code = DCD_CMD_SREF_EXIT;
        end else begin
          cmd_code = DCD_CMD_PDOWN_EXIT;
        end
      end
    end else if (!pins_reg.cke) begin
      cmd_valid = 1'b1;
      if (is_ref && burst_cnt_reg == 3'h0) begin
        cmd_code = DCD_CMD_SREF_ENTER; // R17
      end else if (is_nop_des) begin
        cmd_code = DCD_CMD_PDOWN_ENTER; // R17
      end else begin
        cmd_bad = 1'b1;
      end
    end else if (pins_reg.cs_n) begin
      cmd_valid = 1'b1;
      cmd_code = DCD_CMD_DESELECT; // R11
    end else begin
      cmd_valid = 1'b1;
      case ({pins_reg.ras_n, pins_reg.cas_n, pins_reg.we_n}) // R1
        3'h0: cmd_code = DCD_CMD_MODE_SET; // R4
        3'h1: cmd_code = DCD_CMD_REFRESH;
        3'h2: cmd_code = ap_bit ? DCD_CMD_PRECHARGE_ALL : DCD_CMD_PRECHARGE; // R16
        3'h3: cmd_code = DCD_CMD_ACTIVATE; // R16
        3'h4: cmd_code = DCD_CMD_WRITE; // R5
        3'h5: cmd_code = DCD_CMD_READ; // R6
        3'h6: cmd_code = ap_bit ? DCD_CMD_ZQ_LONG : DCD_CMD_ZQ_SHORT; // R17
        3'h7: cmd_code = DCD_CMD_NOP; // R10
        default: cmd_code = DCD_CMD_NOP;
      endcase
      // a running burst cannot be cut by a new read or write
      if ((cmd_code == DCD_CMD_READ || cmd_code == DCD_CMD_WRITE) &&
          burst_cnt_reg != 3'h0) begin
        cmd_bad = 1'b1; // R9
      end
    end
  end

  // --------------------------------------------------------------------------
  // command output register
  // --------------------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_CMD <= '0;
      O_CMD_ILLEGAL <= 1'b0;
    end else begin
      O_CMD <= '0;
      O_CMD_ILLEGAL <= cmd_bad;
      if (cmd_valid && !cmd_bad) begin
        O_CMD.valid <= 1'b1;
        O_CMD.code <= cmd_code;
        case (cmd_code)
          DCD_CMD_MODE_SET: begin
            O_CMD.bank <= bank; // R4
            O_CMD.opcode <= pins_reg.addr; // R4
          end
          DCD_CMD_PRECHARGE: begin
            O_CMD.bank <= bank; // R3 R16
          end
          DCD_CMD_ACTIVATE: begin
            O_CMD.bank <= bank; // R3
            O_CMD.row <= row; // R16
          end
          DCD_CMD_READ, DCD_CMD_WRITE: begin
            O_CMD.bank <= bank; // R5 R6
            O_CMD.col <= col; // R5 R6
            O_CMD.auto_pre <= ap_bit; // R7
            O_CMD.bc4 <= bc4_sel; // R8
          end
          default: begin
            O_CMD.bank <= '0;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // burst tracking
  // --------------------------------------------------------------------------
  // counts clocks of the data burst; nop, deselect or power-down leave it running
  logic rdwr_go;

  assign rdwr_go = cmd_valid && !cmd_bad &&
                   (cmd_code == DCD_CMD_READ || cmd_code == DCD_CMD_WRITE);

  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      burst_cnt_reg <= 3'h0;
    end else if (rdwr_go) begin
      burst_cnt_reg <= bc4_sel ? `DCD_BC4_CYCLES : `DCD_BL8_CYCLES; // R8
    end else if (burst_cnt_reg != 3'h0) begin
      burst_cnt_reg <= burst_cnt_reg - 3'h1; // R9 R10
    end
  end

  logic burst_busy_reg;

  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      burst_busy_reg <= 1'b0;
    end else begin
      burst_busy_reg <= rdwr_go || (burst_cnt_reg != 3'h0);
    end
  end

  assign O_BURST_BUSY = burst_busy_reg;

  // --------------------------------------------------------------------------
  // power state
  // --------------------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state_reg <= DCD_ST_ACTIVE;
    end else if (cmd_valid && !cmd_bad) begin
      case (cmd_code)
        DCD_CMD_SREF_ENTER: state_reg <= DCD_ST_SREF; // R17
        DCD_CMD_PDOWN_ENTER: state_reg <= DCD_ST_PDOWN; // R17
        DCD_CMD_SREF_EXIT: state_reg <= DCD_ST_ACTIVE;
        DCD_CMD_PDOWN_EXIT: state_reg <= DCD_ST_ACTIVE;
        default: state_reg <= state_reg;
      endcase
    end
  end

  assign O_STATE = state_reg;

  // --------------------------------------------------------------------------
  // refresh engine and termination
  // --------------------------------------------------------------------------
  // internal refresh runs in self refresh only; power-down refreshes nothing
  logic self_ref_reg;
  logic odt_en_reg;

  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      self_ref_reg <= 1'b0;
    end else begin
      self_ref_reg <= (state_reg == DCD_ST_SREF); // R13
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      odt_en_reg <= 1'b0;
    end else begin
      odt_en_reg <= pins_reg.odt && (state_reg != DCD_ST_SREF); // R14
    end
  end

  assign O_SELF_REFRESHING = self_ref_reg;
  assign O_ODT_EN = odt_en_reg;

  // --------------------------------------------------------------------------
  // asynchronous wake from self refresh
  // --------------------------------------------------------------------------
  // the raw pin is used so wake-up does not wait for the clock; limitation:
  // it is a level, so consumers must treat it as a wake request only
  assign O_SREF_WAKE = self_ref_reg && I_PINS.cke; // R12

endmodule : dcd_decoder

// file: dcd_decoder_sva.sv
module dcd_decoder_sva (
  // clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_RST_B,
  // pins and mode
  input wire dcd_pkg::dcd_pins_s I_PINS,
  input wire logic I_OTF_EN,
  // decoder outputs
  input wire dcd_pkg::dcd_cmd_s O_CMD,
  input wire dcd_pkg::dcd_state_e O_STATE,
  input wire logic O_CMD_ILLEGAL,
  input wire logic O_BURST_BUSY,
  input wire logic O_SREF_WAKE,
  input wire logic O_SELF_REFRESHING,
  input wire logic O_ODT_EN
);
  import dcd_pkg::*;
  logic [3:0] strb;
  logic rw;
  assign strb = {I_PINS.cs_n, I_PINS.ras_n, I_PINS.cas_n, I_PINS.we_n};
  assign rw = O_CMD.valid && (O_CMD.code == DCD_CMD_READ || O_CMD.code == DCD_CMD_WRITE);
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RST_B);
  // ---------------------------------------------------------------------------
  // decode is three edges behind the pins: two sync stages plus the output
  // ---------------------------------------------------------------------------
  read_strobes_a: assert property (O_CMD.valid && O_CMD.code == DCD_CMD_READ |->
    $past(strb, 3) == 4'h5 && $past(I_PINS.cke, 4)) else $error("read without read pins");
  write_strobes_a: assert property (O_CMD.valid && O_CMD.code == DCD_CMD_WRITE |->
    $past(strb, 3) == 4'h4) else $error("write without write pins");
  mode_set_a: assert property (O_CMD.valid && O_CMD.code == DCD_CMD_MODE_SET |->
    $past(strb, 3) == 4'h0 && O_CMD.opcode == $past(I_PINS.addr, 3)
    && O_CMD.bank == $past(I_PINS.ba, 3)) else $error("mode set fields wrong");
  auto_pre_a: assert property (rw |-> O_CMD.auto_pre == $past(I_PINS.addr[10], 3))
    else $error("auto precharge flag wrong");
  burst_chop_a: assert property (rw && $past(I_OTF_EN) |->
    O_CMD.bc4 == !$past(I_PINS.addr[12], 3)) else $error("burst chop wrong");
  burst_hold_a: assert property (rw && !O_CMD.bc4 |-> O_BURST_BUSY [*4])
    else $error("burst cut short");
  deselect_quiet_a: assert property ($past(I_PINS.cs_n, 3) && $past(I_PINS.cke, 3)
    && $past(I_PINS.cke, 4) |-> !O_CMD_ILLEGAL) else $error("deselect refused");
  sre_cause_a: assert property (O_CMD.valid && O_CMD.code == DCD_CMD_SREF_ENTER |->
    $past(strb, 3) == 4'h1 && $past(I_PINS.cke, 4) && !$past(I_PINS.cke, 3))
    else $error("self refresh entry without cause");
  odt_off_a: assert property (O_SELF_REFRESHING && $past(O_SELF_REFRESHING) |-> !O_ODT_EN)
    else $error("termination on in self refresh");
  pdown_quiet_a: assert property (O_STATE == DCD_ST_PDOWN |-> !O_SELF_REFRESHING)
    else $error("refresh during power-down");
  wake_async_a: assert property (O_SREF_WAKE == (O_SELF_REFRESHING && I_PINS.cke))
    else $error("wake does not follow clock enable");
  cover property (rw && O_CMD.bc4);
  cover property (O_STATE == DCD_ST_SREF);
  cover property (O_CMD_ILLEGAL);
endmodule : dcd_decoder_sva

bind dcd_decoder dcd_decoder_sva u_dcd_decoder_sva (.I_SYS_CLK, .I_RST_B, .I_PINS, .I_OTF_EN,
  .O_CMD, .O_STATE, .O_CMD_ILLEGAL, .O_BURST_BUSY, .O_SREF_WAKE, .O_SELF_REFRESHING, .O_ODT_EN);

// file: dcd_ctrl_model.sv
module dcd_ctrl_model (
  // clock
  input wire logic i_clk,
  // command pins toward the device
  output dcd_pkg::dcd_pins_s o_pins
);
  import dcd_pkg::*;
  // deselected with clock enable low, as a controller holds them during reset
  initial o_pins = 25'h1E80000;
  // one command per clock; pins move only after the falling edge, clear of sampling
  task automatic put(input logic [3:0] strb, input logic cke, input logic [15:0] addr);
    @(negedge i_clk);
    {o_pins.cs_n, o_pins.ras_n, o_pins.cas_n, o_pins.we_n} = strb;
    o_pins.cke = cke;
    o_pins.odt = 1'h1;
    o_pins.ba = 3'h5;
    o_pins.addr = addr;
  endtask : put
endmodule : dcd_ctrl_model

// file: tb_dcd_decoder.sv
module tb_dcd_decoder;
  timeunit 1ns;
  timeprecision 1ps;
  import dcd_pkg::*;
  logic sys_clk = 1'h0;
  logic rst_b = 1'h0;
  logic otf_en = 1'h1;
  logic fixed_bc4 = 1'h0;
  dcd_pins_s pins;
  dcd_cmd_s cmd;
  dcd_state_e state;
  logic illegal, busy, wake, srefing, odt_en;
  int err_total = 0;
  int checked = 0;
  initial forever #25 sys_clk = ~sys_clk;
  dcd_ctrl_model u_dcd_ctrl_model (.i_clk(sys_clk), .o_pins(pins));
  dcd_decoder u_dcd_decoder (.I_SYS_CLK(sys_clk), .I_RST_B(rst_b), .I_PINS(pins),
    .I_OTF_EN(otf_en), .I_FIXED_BC4(fixed_bc4), .O_CMD(cmd), .O_STATE(state),
    .O_CMD_ILLEGAL(illegal), .O_BURST_BUSY(busy), .O_SREF_WAKE(wake),
    .O_SELF_REFRESHING(srefing), .O_ODT_EN(odt_en));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    if (err_total == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  // command, then nop at the same clock enable; returns where the decode shows
  task automatic go(input logic [3:0] s, input logic k, input logic [15:0] a);
    u_dcd_ctrl_model.put(s, k, a);
    u_dcd_ctrl_model.put(4'h7, k, 16'h0000);
    repeat (2) @(negedge sys_clk);
  endtask : go
  task automatic t_codes;
    logic [3:0] s [8] = '{4'h0, 4'h1, 4'h2, 4'h2, 4'h3, 4'h6, 4'h6, 4'h4};
    logic [15:0] a [8] = '{16'h1234, 16'h0000, 16'h0000, 16'h0400, 16'h4321, 16'h0400,
      16'h0000, 16'h1000};
    dcd_cmd_e e [8] = '{DCD_CMD_MODE_SET, DCD_CMD_REFRESH, DCD_CMD_PRECHARGE,
      DCD_CMD_PRECHARGE_ALL, DCD_CMD_ACTIVATE, DCD_CMD_ZQ_LONG, DCD_CMD_ZQ_SHORT, DCD_CMD_WRITE};
    for (int i = 0; i < 8; i++) begin
      go(s[i], 1'h1, a[i]);
      chk(cmd.valid, 1'h1);
      chk(cmd.code, e[i]);
      if (i inside {0, 2, 4, 7}) chk(cmd.bank, 3'h5);
      if (i == 0) chk(cmd.opcode, 16'h1234);
      if (i == 4) chk(cmd.row, 16'h4321);
    end
  endtask : t_codes
  task automatic t_desel;
    go(4'h8, 1'h1, 16'hFFFF);
    chk(illegal, 1'h0);
    chk(cmd.valid && !(cmd.code inside {DCD_CMD_NOP, DCD_CMD_DESELECT}), 1'h0);
    chk(odt_en, 1'h1);
  endtask : t_desel
  task automatic t_burst;
    repeat (4) @(negedge sys_clk);
    u_dcd_ctrl_model.put(4'h5, 1'h1, 16'h1400);
    u_dcd_ctrl_model.put(4'h5, 1'h1, 16'h0000);
    u_dcd_ctrl_model.put(4'h7, 1'h1, 16'h0000);
    @(negedge sys_clk);
    chk(cmd.code, DCD_CMD_READ);
    chk({cmd.auto_pre, cmd.bc4, busy}, 3'h5);
    @(negedge sys_clk);
    chk(illegal, 1'h1);
    repeat (2) @(negedge sys_clk);
    chk(busy, 1'h1);
    @(negedge sys_clk);
    chk(busy, 1'h0);
    go(4'h5, 1'h1, 16'h2A55);
    chk({cmd.valid, cmd.auto_pre, cmd.bc4}, 3'h5);
    chk(cmd.col, 16'h0255);
    chk(cmd.bank, 3'h5);
    otf_en = 1'h0;
    fixed_bc4 = 1'h1;
    repeat (3) @(negedge sys_clk);
    go(4'h4, 1'h1, 16'h1000);
    chk({cmd.code, cmd.bc4}, {DCD_CMD_WRITE, 1'h1});
    otf_en = 1'h1;
    repeat (3) @(negedge sys_clk);
  endtask : t_burst
  task automatic t_sref;
    go(4'h1, 1'h0, 16'h0000);
    chk(cmd.code, DCD_CMD_SREF_ENTER);
    repeat (2) @(negedge sys_clk);
    chk({state, srefing, odt_en}, {DCD_ST_SREF, 2'h2});
    u_dcd_ctrl_model.put(4'h7, 1'h1, 16'h0000);
    #1;
    chk(wake, 1'h1);
    repeat (3) @(negedge sys_clk);
    chk(cmd.code, DCD_CMD_SREF_EXIT);
    @(negedge sys_clk);
    chk(state, DCD_ST_ACTIVE);
  endtask : t_sref
  task automatic t_pdown;
    go(4'h7, 1'h0, 16'h0000);
    chk(cmd.code, DCD_CMD_PDOWN_ENTER);
    @(negedge sys_clk);
    chk({state, srefing}, {DCD_ST_PDOWN, 1'h0});
    u_dcd_ctrl_model.put(4'h3, 1'h1, 16'h0000);
    u_dcd_ctrl_model.put(4'h7, 1'h0, 16'h0000);
    repeat (2) @(negedge sys_clk);
    chk({illegal, state}, {1'h1, DCD_ST_PDOWN});
    go(4'h7, 1'h1, 16'h0000);
    chk(cmd.code, DCD_CMD_PDOWN_EXIT);
    @(negedge sys_clk);
    chk(state, DCD_ST_ACTIVE);
  endtask : t_pdown
  initial begin
    repeat (20) @(negedge sys_clk);
    rst_b = 1'h1;
    u_dcd_ctrl_model.put(4'h7, 1'h1, 16'h0000);
    repeat (4) @(negedge sys_clk);
    t_codes;
    t_desel;
    t_burst;
    t_sref;
    t_pdown;
    wrap_up;
  end
  // the sequence needs well under a thousand clocks
  initial begin
    repeat (2000) @(posedge sys_clk);
    err_total++;
    wrap_up;
  end
endmodule : tb_dcd_decoder
